// ### common/uff_pkg.sv
package uff_pkg;
  // ==========================================================
  // widths
  localparam int LEN_W = 16;
  localparam int MS_W = 8;
  localparam int SEQ_W = 4;
  localparam int RTY_W = 4;
  localparam int TMR_W = 16;
  // ==========================================================
  // fragment overhead: header, header check, trailer crc
  localparam logic [LEN_W-1:0] FRAG_OH = 16'h0010;
  // ==========================================================
  // reset values
  localparam logic [LEN_W-1:0] LEN_RST = 16'h0000;
  localparam logic [MS_W-1:0] MS_RST = 8'h00;
  localparam logic [SEQ_W-1:0] SEQ_RST = 4'h0;
  localparam logic [RTY_W-1:0] RTY_RST = 4'h0;
  localparam logic [TMR_W-1:0] TMR_RST = 16'h0000;
  // ==========================================================
  // states
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ  = 4'h2,
    ST_WAIT = 4'h4,
    ST_SEND = 4'h8
  } uff_state_t;
endpackage

// ### hdl/uff_frame_mem.sv
`timescale 1ns/1ps
// ==========================================================
// frame store, one write port, registered read port
module uff_frame_mem #(
  parameter int AW = 11,
  parameter int DW = 8
) (
  // clock
  input wire logic clk_i,
  // write side
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [DW-1:0] wr_data_i,
  // read side
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [DW-1:0] rd_data_o
);
  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rd_en_i) begin
      rd_data_o <= mem_r[rd_addr_i];
    end
  end
endmodule

// ### hdl/uff_fragmenter.sv
`timescale 1ns/1ps
module uff_fragmenter #(
  parameter int AW = 11
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // configuration
  input wire logic frag_en_i,
  input wire logic [uff_pkg::RTY_W-1:0] retry_limit_i,
  input wire logic [uff_pkg::TMR_W-1:0] ack_cycles_i,
  input wire logic [uff_pkg::MS_W-1:0] bytes_per_ms_i,
  input wire logic [uff_pkg::MS_W-1:0] phy_overhead_i,
  // frame store write
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // packet queue
  input wire logic pkt_valid_i,
  input wire logic [uff_pkg::LEN_W-1:0] pkt_len_i,
  input wire logic pkt_immediate_i,
  input wire logic next_pkt_valid_i,
  input wire logic [uff_pkg::LEN_W-1:0] next_pkt_len_i,
  // allocation map events for this flow_identifier
  input wire logic grant_valid_i,
  input wire logic [uff_pkg::MS_W-1:0] grant_ms_i,
  input wire logic more_grants_i,
  input wire logic grant_pending_i,
  // contention request
  output logic req_valid_o,
  output logic [uff_pkg::MS_W-1:0] req_ms_o,
  // fragment_header fields
  output logic frag_start_o,
  output logic frag_mode_o,
  output logic frag_first_o,
  output logic frag_last_o,
  output logic [uff_pkg::SEQ_W-1:0] frag_seq_o,
  output logic [uff_pkg::MS_W-1:0] frag_piggy_o,
  output logic [uff_pkg::LEN_W-1:0] frag_len_o,
  // payload bytes
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  // status
  output logic pkt_done_o,
  output logic pkt_drop_o,
  output logic busy_o
);
  localparam int LW = uff_pkg::LEN_W;

  // ==========================================================
  // reset release
  logic rst_s1_r;
  logic rst_n;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end

  // ==========================================================
  // byte to minislot, rounded up, saturated
  function automatic logic [uff_pkg::MS_W-1:0] to_ms(input logic [LW-1:0] bytes,
                                                   input logic [7:0] bpm, input logic [7:0] phy);
    logic [LW+1:0] sum;
    logic [LW+1:0] q;
    sum = {2'b00, bytes} + {{(LW-6){1'b0}}, phy} + {{(LW-6){1'b0}}, bpm} - 18'h00001;
    q = (bpm == 8'h00) ? 18'h3FFFF : sum / {{(LW-6){1'b0}}, bpm};
    to_ms = (q > 18'h000FF) ? 8'hFF : q[7:0];
  endfunction

  // ==========================================================
  // state
  uff_pkg::uff_state_t state_r;
  uff_pkg::uff_state_t state_nxt;
  logic [LW-1:0] remain_r;
  logic [LW-1:0] offset_r;
  logic [LW-1:0] cnt_r;
  logic fragging_r;
  logic imm_r;
  logic [uff_pkg::RTY_W-1:0] retry_r;
  logic [uff_pkg::TMR_W-1:0] timer_r;

  // ==========================================================
  // grant evaluation
  logic [LW-1:0] cap;
  logic [LW-1:0] need;
  logic [LW-1:0] pay;
  logic [LW-1:0] raw_cap;
  logic fits;
  logic can_frag;
  logic take;
  logic expire;
  logic [uff_pkg::MS_W-1:0] piggy;

  always_comb begin
    raw_cap = {8'h00, grant_ms_i} * {8'h00, bytes_per_ms_i};
    cap = (raw_cap > {8'h00, phy_overhead_i}) ? raw_cap - {8'h00, phy_overhead_i} : uff_pkg::LEN_RST;
    need = fragging_r ? remain_r + uff_pkg::FRAG_OH : remain_r;
    fits = cap >= need;
    can_frag = frag_en_i && !imm_r && (cap > uff_pkg::FRAG_OH);
    pay = fits ? remain_r : cap - uff_pkg::FRAG_OH;
    take = grant_valid_i && (fits || can_frag);
    if (fits && (!next_pkt_valid_i || more_grants_i)) begin
      piggy = uff_pkg::MS_RST;
    end else if (fits) begin
      piggy = to_ms(next_pkt_len_i, bytes_per_ms_i, phy_overhead_i);
    end else if (more_grants_i) begin
      piggy = uff_pkg::MS_RST;
    end else begin
      piggy = to_ms(remain_r - pay + uff_pkg::FRAG_OH, bytes_per_ms_i, phy_overhead_i);
    end
    expire = (timer_r == uff_pkg::TMR_RST) && !grant_pending_i && !grant_valid_i;
  end

  wire send_done = (state_r == uff_pkg::ST_SEND) && (cnt_r == frag_len_o);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      uff_pkg::ST_IDLE: begin
        if (pkt_valid_i) begin
          state_nxt = pkt_immediate_i ? uff_pkg::ST_SEND : uff_pkg::ST_REQ;
        end
      end
      uff_pkg::ST_REQ: state_nxt = uff_pkg::ST_WAIT;
      uff_pkg::ST_WAIT: begin
        if (take) begin
          state_nxt = uff_pkg::ST_SEND;
        end else if (expire) begin
          state_nxt = (retry_r == retry_limit_i) ? uff_pkg::ST_IDLE : uff_pkg::ST_REQ;
        end
      end
      uff_pkg::ST_SEND: begin
        if (send_done) begin
          state_nxt = (frag_last_o || !frag_mode_o) ? uff_pkg::ST_IDLE : uff_pkg::ST_WAIT;
        end
      end
      default: state_nxt = uff_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= uff_pkg::ST_IDLE;
      busy_o <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_o <= state_nxt != uff_pkg::ST_IDLE;
    end
  end

  // ==========================================================
  // frame progress
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      remain_r <= uff_pkg::LEN_RST;
      offset_r <= uff_pkg::LEN_RST;
      fragging_r <= 1'b0;
      imm_r <= 1'b0;
    end else if (state_r == uff_pkg::ST_IDLE && pkt_valid_i) begin
      remain_r <= pkt_len_i;
      offset_r <= uff_pkg::LEN_RST;
      fragging_r <= 1'b0;
      imm_r <= pkt_immediate_i;
    end else if (send_done && frag_mode_o && !frag_last_o) begin
      remain_r <= remain_r - frag_len_o;
      offset_r <= offset_r + frag_len_o;
      fragging_r <= 1'b1;
    end
  end

  // ack timer and retries; any grant or pending refreshes the wait
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      timer_r <= uff_pkg::TMR_RST;
      retry_r <= uff_pkg::RTY_RST;
    end else if (state_r == uff_pkg::ST_IDLE) begin
      retry_r <= uff_pkg::RTY_RST;
    end else if (state_r == uff_pkg::ST_REQ || send_done) begin
      timer_r <= ack_cycles_i;
    end else if (state_r == uff_pkg::ST_WAIT) begin
      if (grant_valid_i || grant_pending_i) begin
        timer_r <= ack_cycles_i;
        retry_r <= take ? uff_pkg::RTY_RST : retry_r;
      end else if (expire) begin
        retry_r <= retry_r + 4'h1;
      end else begin
        timer_r <= timer_r - 16'h0001;
      end
    end
  end

  // contention request, remainder includes overhead once fragmenting
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      req_valid_o <= 1'b0;
      req_ms_o <= uff_pkg::MS_RST;
      pkt_drop_o <= 1'b0;
      pkt_done_o <= 1'b0;
    end else begin
      req_valid_o <= state_r == uff_pkg::ST_REQ;
      req_ms_o <= to_ms(need, bytes_per_ms_i, phy_overhead_i);
      pkt_drop_o <= (state_r == uff_pkg::ST_WAIT) && expire && (retry_r == retry_limit_i);
      pkt_done_o <= send_done && (frag_last_o || !frag_mode_o);
    end
  end

  // ==========================================================
  // fragment header fields, loaded when a packet is accepted and latched when a grant is taken
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      frag_start_o <= 1'b0;
      frag_mode_o <= 1'b0;
      frag_first_o <= 1'b0;
      frag_last_o <= 1'b0;
      frag_seq_o <= uff_pkg::SEQ_RST;
      frag_piggy_o <= uff_pkg::MS_RST;
      frag_len_o <= uff_pkg::LEN_RST;
    end else if (state_r == uff_pkg::ST_IDLE && pkt_valid_i) begin
      frag_start_o <= pkt_immediate_i;
      frag_mode_o <= 1'b0;
      frag_first_o <= 1'b0;
      frag_last_o <= 1'b0;
      frag_seq_o <= uff_pkg::SEQ_RST;
      frag_piggy_o <= uff_pkg::MS_RST;
      frag_len_o <= pkt_len_i;
    end else if (state_r == uff_pkg::ST_WAIT && take) begin
      frag_start_o <= 1'b1;
      frag_mode_o <= fragging_r || !fits;
      frag_first_o <= !fragging_r && !fits;
      frag_last_o <= fragging_r && fits;
      frag_seq_o <= fragging_r ? frag_seq_o + 4'h1 : uff_pkg::SEQ_RST;
      frag_piggy_o <= (fragging_r || !fits) ? piggy : uff_pkg::MS_RST;
      frag_len_o <= pay;
    end else begin
      frag_start_o <= 1'b0;
    end
  end

  // ==========================================================
  // payload read-out, one byte a cycle
  logic rd_en;
  assign rd_en = (state_r == uff_pkg::ST_SEND) && (cnt_r != frag_len_o);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= uff_pkg::LEN_RST;
      tx_valid_o <= 1'b0;
      tx_last_o <= 1'b0;
    end else begin
      cnt_r <= (state_r == uff_pkg::ST_SEND) ? cnt_r + (rd_en ? 16'h0001 : 16'h0000) : uff_pkg::LEN_RST;
      tx_valid_o <= rd_en;
      tx_last_o <= rd_en && (cnt_r + 16'h0001 == frag_len_o);
    end
  end

  uff_frame_mem #(.AW(AW), .DW(8)) uff_frame_mem_inst (
    .clk_i(clk_i),
    .wr_en_i(wr_en_i),
    .wr_addr_i(wr_addr_i),
    .wr_data_i(wr_data_i),
    .rd_en_i(rd_en),
    .rd_addr_i(AW'(offset_r + cnt_r)),
    .rd_data_o(tx_data_o)
  );

  // ==========================================================
  // checks
  logic [LW-1:0] cap_h;
  logic more_h;
  logic [uff_pkg::SEQ_W-1:0] seq_h;
  always_ff @(posedge clk_i) begin
    if (state_r == uff_pkg::ST_WAIT && take) begin
      cap_h <= cap;
      more_h <= more_grants_i;
    end
    if (frag_start_o) begin
      seq_h <= frag_seq_o;
    end
  end

  sequence s_expiry;
    state_r == uff_pkg::ST_WAIT && expire && retry_r != retry_limit_i;
  endsequence
  sequence s_rerequest;
    state_r == uff_pkg::ST_REQ ##1 req_valid_o;
  endsequence

  property p_request_follows;
    @(posedge clk_i) disable iff (!rst_n)
      (state_r == uff_pkg::ST_IDLE && pkt_valid_i && !pkt_immediate_i) |=> ##1 req_valid_o;
  endproperty
  a_request_follows: assert property (p_request_follows) else $error("no request for packet");

  property p_drop;
    @(posedge clk_i) disable iff (!rst_n)
      (state_r == uff_pkg::ST_WAIT && expire && retry_r == retry_limit_i) |=> pkt_drop_o && state_r == uff_pkg::ST_IDLE;
  endproperty
  a_drop: assert property (p_drop) else $error("packet not dropped after retries");

  property p_rerequest;
    @(posedge clk_i) disable iff (!rst_n) s_expiry |=> s_rerequest;
  endproperty
  a_rerequest: assert property (p_rerequest) else $error("no re-request on timeout");

  property p_payload;
    @(posedge clk_i) disable iff (!rst_n)
      (frag_start_o && frag_mode_o && !frag_last_o) |-> frag_len_o + uff_pkg::FRAG_OH == cap_h;
  endproperty
  a_payload: assert property (p_payload) else $error("fragment payload size wrong");

  property p_flags;
    @(posedge clk_i) disable iff (!rst_n)
      (frag_start_o && frag_mode_o) |-> !(frag_first_o && frag_last_o) && (frag_first_o == (frag_seq_o == 4'h0));
  endproperty
  a_flags: assert property (p_flags) else $error("fragment flags wrong");

  property p_seq;
    @(posedge clk_i) disable iff (!rst_n)
      (frag_start_o && frag_mode_o && !frag_first_o) |-> frag_seq_o == seq_h + 4'h1;
  endproperty
  a_seq: assert property (p_seq) else $error("sequence not incremented");

  property p_no_piggy;
    @(posedge clk_i) disable iff (!rst_n)
      (frag_start_o && frag_mode_o && more_h) |-> frag_piggy_o == uff_pkg::MS_RST;
  endproperty
  a_no_piggy: assert property (p_no_piggy) else $error("piggyback with grants queued");

  property p_immediate;
    @(posedge clk_i) disable iff (!rst_n) (frag_start_o && imm_r) |-> !frag_mode_o;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate frame fragmented");

  property p_stream;
    @(posedge clk_i) disable iff (!rst_n)
      (frag_start_o && frag_len_o == 16'h0001) |-> ##1 tx_valid_o && tx_last_o ##1 !tx_valid_o;
  endproperty
  a_stream: assert property (p_stream) else $error("payload stream length wrong");
endmodule

// ### verif/uff_headend_model.sv
`timescale 1ns/1ps
// ==========================================================
// headend scheduler: grants cap_i minislots a few cycles after a request
// or after a non-final fragment, as a multiple grant scheduler would
module uff_headend_model #(
  parameter int DLY = 5
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // behaviour
  input wire logic [uff_pkg::MS_W-1:0] cap_i,
  input wire logic more_i,
  input wire logic mute_i,
  // modem side
  input wire logic req_valid_i,
  input wire logic tx_last_i,
  input wire logic frag_mode_i,
  input wire logic frag_last_i,
  // allocation map events
  output logic grant_valid_o = 1'b0,
  output logic [uff_pkg::MS_W-1:0] grant_ms_o = 8'h00,
  output logic more_grants_o = 1'b0,
  output logic grant_pending_o = 1'b0
);
  int cnt;
  logic fire;
  assign fire = (cnt == 1) && !mute_i && nrst_i;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) cnt <= 0;
    else if (req_valid_i || (tx_last_i && frag_mode_i && !frag_last_i)) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // fields outside a grant toggle, so a stale value is never reused
  always @(negedge clk_i) begin
    grant_valid_o <= fire;
    grant_ms_o <= fire ? cap_i : ~grant_ms_o;
    more_grants_o <= fire ? more_i : ~more_grants_o;
    grant_pending_o <= more_i && grant_valid_o;
  end
endmodule

// ### verif/uff_fragmenter_tb_top.sv
`timescale 1ns/1ps
module uff_fragmenter_tb_top;
  // ==========================================================
  // stimulus
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic frag_en_i = 1'b1;
  logic [3:0] retry_limit_i = 4'h2;
  logic [15:0] ack_cycles_i = 16'h00C8;
  logic [7:0] bpm = 8'h10;
  logic [7:0] phy = 8'h08;
  logic wr_en_i = 1'b0;
  logic [10:0] wr_addr_i = 11'h000;
  logic [7:0] wr_data_i = 8'h00;
  logic pkt_valid_i = 1'b0;
  logic [15:0] pkt_len_i = 16'h0000;
  logic pkt_imm = 1'b0;
  logic next_pkt_valid_i = 1'b0;
  logic [15:0] next_pkt_len_i = 16'h0032;
  logic [7:0] cap = 8'h04;
  logic more = 1'b0;
  logic mute = 1'b0;
  logic gv, mg, gp, req_valid_o, fs, fmode, ffirst, flast, tv, tl, done, drop, busy_o;
  logic [7:0] gms, req_ms_o, piggy, tx_data_o;
  logic [3:0] fseq;
  logic [15:0] flen;
  int error_cnt = 0;
  int check_count = 0;
  int idx = 0;
  int fcnt = 0;
  int req_cnt = 0;
  int fs_cnt = 0;
  initial forever #12.5 clk_i = ~clk_i;
  uff_fragmenter uff_fragmenter_inst (.clk_i(clk_i), .nrst_i(nrst_i), .frag_en_i(frag_en_i),
    .retry_limit_i(retry_limit_i), .ack_cycles_i(ack_cycles_i), .bytes_per_ms_i(bpm), .phy_overhead_i(phy),
    .wr_en_i(wr_en_i), .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .pkt_valid_i(pkt_valid_i),
    .pkt_len_i(pkt_len_i), .pkt_immediate_i(pkt_imm), .next_pkt_valid_i(next_pkt_valid_i),
    .next_pkt_len_i(next_pkt_len_i), .grant_valid_i(gv), .grant_ms_i(gms), .more_grants_i(mg),
    .grant_pending_i(gp), .req_valid_o(req_valid_o), .req_ms_o(req_ms_o), .frag_start_o(fs),
    .frag_mode_o(fmode), .frag_first_o(ffirst), .frag_last_o(flast), .frag_seq_o(fseq),
    .frag_piggy_o(piggy), .frag_len_o(flen), .tx_valid_o(tv), .tx_data_o(tx_data_o), .tx_last_o(tl),
    .pkt_done_o(done), .pkt_drop_o(drop), .busy_o(busy_o));
  uff_headend_model uff_headend_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .cap_i(cap), .more_i(more),
    .mute_i(mute), .req_valid_i(req_valid_o), .tx_last_i(tl), .frag_mode_i(fmode), .frag_last_i(flast),
    .grant_valid_o(gv), .grant_ms_o(gms), .more_grants_o(mg), .grant_pending_o(gp));
  // ==========================================================
  // helpers
  function automatic logic [7:0] pat(input int i);
    return i[7:0] ^ 8'hA5;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tmo(input logic ok, input string what);
    if (!ok) begin
      error_cnt++;
      $display("MISMATCH t=%0t timeout on %s", $time, what);
      close_out();
    end
  endtask
  task automatic send_pkt(input logic [15:0] len, input logic imm);
    int n;
    for (n = 0; n < 4000 && busy_o !== 1'b0; n++) @(negedge clk_i);
    tmo(busy_o === 1'b0, "idle");
    idx = 0;
    req_cnt = 0;
    fs_cnt = 0;
    pkt_len_i = len;
    pkt_imm = imm;
    pkt_valid_i = 1'b1;
    for (n = 0; n < 20 && busy_o !== 1'b1; n++) @(negedge clk_i);
    tmo(busy_o === 1'b1, "busy");
    pkt_valid_i = 1'b0;
  endtask
  task automatic wait_req(input logic [7:0] ms);
    int n;
    for (n = 0; n < 4000 && req_valid_o !== 1'b1; n++) @(negedge clk_i);
    tmo(req_valid_o === 1'b1, "request");
    chk(req_ms_o, ms, "req_ms");
    @(negedge clk_i);
  endtask
  task automatic wait_frag(input logic md, input logic f, input logic l, input logic [3:0] off,
                           input logic [15:0] len, input logic [7:0] pg);
    int n;
    for (n = 0; n < 4000 && fs !== 1'b1; n++) @(negedge clk_i);
    tmo(fs === 1'b1, "fragment");
    chk(fmode, md, "mode");
    chk(ffirst, f, "first");
    chk(flast, l, "last");
    chk(fseq, {12'h000, off}, "seq");
    chk(flen, len, "length");
    chk(piggy, pg, "piggyback");
    @(negedge clk_i);
  endtask
  task automatic wait_end(input logic dr, input string name);
    int n;
    for (n = 0; n < 4000 && done !== 1'b1 && drop !== 1'b1; n++) @(negedge clk_i);
    tmo(done === 1'b1 || drop === 1'b1, "end of packet");
    chk(drop, dr, "drop");
    @(negedge clk_i);
    $display("test %s finished", name);
  endtask
  // payload must continue byte by byte across fragment boundaries
  always @(negedge clk_i) begin
    if (req_valid_o === 1'b1) req_cnt++;
    if (fs === 1'b1) fs_cnt++;
    if (tv === 1'b1) begin
      chk(tx_data_o, pat(idx), "payload byte");
      idx++;
      fcnt++;
      if (tl === 1'b1) begin
        chk(fcnt, flen, "bytes in fragment");
        fcnt = 0;
      end
    end
  end
  // ==========================================================
  // sequence
  initial begin
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (3) @(negedge clk_i);
    for (int i = 0; i < 100; i++) begin
      wr_en_i = 1'b1;
      wr_addr_i = i[10:0];
      wr_data_i = pat(i);
      @(negedge clk_i);
    end
    wr_en_i = 1'b0;
    // piggyback mode, next packet queued: 108 bytes need 7 slots, 56 usable per grant
    next_pkt_valid_i = 1'b1;
    send_pkt(16'h0064, 1'b0);
    wait_req(8'h07);
    wait_frag(1'b1, 1'b1, 1'b0, 4'h0, 16'h0028, 8'h06);
    wait_frag(1'b1, 1'b0, 1'b0, 4'h1, 16'h0028, 8'h03);
    wait_frag(1'b1, 1'b0, 1'b1, 4'h2, 16'h0014, 8'h04);
    wait_end(1'b0, "piggyback");
    // multiple grant mode: grants queued, every request field zero
    more = 1'b1;
    send_pkt(16'h0064, 1'b0);
    wait_req(8'h07);
    wait_frag(1'b1, 1'b1, 1'b0, 4'h0, 16'h0028, 8'h00);
    wait_frag(1'b1, 1'b0, 1'b0, 4'h1, 16'h0028, 8'h00);
    wait_frag(1'b1, 1'b0, 1'b1, 4'h2, 16'h0014, 8'h00);
    wait_end(1'b0, "multiple grant");
    // full grant: back to normal, sent whole
    more = 1'b0;
    cap = 8'h07;
    send_pkt(16'h0064, 1'b0);
    wait_frag(1'b0, 1'b0, 1'b0, 4'h0, 16'h0064, 8'h00);
    wait_end(1'b0, "whole");
    // ack timer runs out mid-fragmentation, nothing else queued
    cap = 8'h04;
    next_pkt_valid_i = 1'b0;
    send_pkt(16'h0064, 1'b0);
    wait_req(8'h07);
    wait_frag(1'b1, 1'b1, 1'b0, 4'h0, 16'h0028, 8'h06);
    mute = 1'b1;
    wait_req(8'h06);
    mute = 1'b0;
    wait_frag(1'b1, 1'b0, 1'b0, 4'h1, 16'h0028, 8'h03);
    wait_frag(1'b1, 1'b0, 1'b1, 4'h2, 16'h0014, 8'h00);
    wait_end(1'b0, "ack timeout");
    // immediate data frame never fragmented, no request
    send_pkt(16'h001E, 1'b1);
    wait_frag(1'b0, 1'b0, 1'b0, 4'h0, 16'h001E, 8'h00);
    wait_end(1'b0, "immediate");
    chk(req_cnt, 16'h0000, "requests");
    // single byte frame drives the one-byte stream check
    send_pkt(16'h0001, 1'b1);
    wait_frag(1'b0, 1'b0, 1'b0, 4'h0, 16'h0001, 8'h00);
    wait_end(1'b0, "single byte");
    // silent headend: one re-request then the packet is abandoned
    mute = 1'b1;
    retry_limit_i = 4'h1;
    send_pkt(16'h0064, 1'b0);
    wait_end(1'b1, "retry");
    chk(req_cnt, 16'h0002, "requests");
    chk(fs_cnt, 16'h0000, "fragments");
    // short grant with fragmentation off is unusable
    mute = 1'b0;
    frag_en_i = 1'b0;
    retry_limit_i = 4'h0;
    send_pkt(16'h0064, 1'b0);
    wait_end(1'b1, "disabled");
    chk(req_cnt, 16'h0001, "requests");
    chk(fs_cnt, 16'h0000, "fragments");
    close_out();
  end
endmodule
